// ---- design/rheo_serial_cmd.sv ----
/*
 * Serial command interpreter of a single-channel digital rheostat:
 * frame shifting, command decode, wiper and control registers, fuse
 * slot bookkeeping, readback and the open-drain serial output.
 * Assumes frame select, serial clock and data come from an SPI host
 * asynchronous to ref_clk_in, with serial clock well below 1/4 of it.
 */
`timescale 1ns/1ns

module rheo_serial_cmd
    import rheo_pkg::*;
#(
    parameter int unsigned FUSE_PROG_CYCLES = `FUSE_PROG_CYCLES
)
(
    // Clock and reset
    input  wire logic       ref_clk_in,
    input  wire logic       rstn_in,
    // Serial link
    input  wire logic       sync_n_in,
    input  wire logic       sclk_in,
    input  wire logic       din_in,
    output logic            serial_data_out_out,
    output logic            serial_data_out_oe_n_out,
    // Rheostat state
    output logic [9:0]      wiper_position_register_out,
    output logic            shutdown_out,
    output logic            tolerance_calib_enable_out,
    output logic            fuse_busy_out
);

    logic [2:0]  pins;
    logic        sync_n;
    logic        sclk;
    logic        din;
    logic        sclk_d;
    logic        sync_d;

    pin_sync u_sync
    (
        .ref_clk_in (ref_clk_in),
        .rstn_in    (rstn_in),
        .pins_in    ({sync_n_in, sclk_in, din_in}),
        .pins_out   (pins)
    );

    assign sync_n = pins[2];
    assign sclk   = pins[1];
    assign din    = pins[0];

    // Edge detection on synchronised copies only
    logic sclk_rise;
    logic sclk_fall;
    logic frame_end;
    assign sclk_rise = sclk & ~sclk_d & ~sync_n;
    assign sclk_fall = ~sclk & sclk_d & ~sync_n;
    assign frame_end = sync_n & ~sync_d;

    function automatic logic cmd_defined(input logic [3:0] c);
        cmd_defined = (c <= `CMD_SHUTDOWN);
    endfunction : cmd_defined

    // State
    logic [15:0] shift_in;
    logic [15:0] out_word;
    logic [3:0]  bit_cnt;
    logic        misaligned;
    logic [15:0] prev_word;
    readback_t   rb_kind;
    logic [15:0] rb_word;
    ctrl_t       ctrl;
    logic [9:0]  wiper;
    logic [5:0]  last_slot;
    logic        shutdown;
    logic        sdo_arm;
    logic        sdo_off;
    logic [31:0] lock_cnt;
    logic        sdo_low;
    logic        mem_wr;
    logic [5:0]  mem_addr;
    logic [1:0]  rst_pend;
    logic [9:0]  mem_q;
    logic        sdo_oe_n;
    logic        busy;

    logic [15:0] next_shift_in;
    logic [15:0] next_out_word;
    logic [3:0]  next_bit_cnt;
    logic        next_misaligned;
    logic [15:0] next_prev_word;
    readback_t   next_rb_kind;
    logic [15:0] next_rb_word;
    ctrl_t       next_ctrl;
    logic [9:0]  next_wiper;
    logic [5:0]  next_last_slot;
    logic        next_shutdown;
    logic        next_sdo_arm;
    logic        next_sdo_off;
    logic [31:0] next_lock_cnt;
    logic        next_sdo_low;
    logic        next_mem_wr;
    logic [5:0]  next_mem_addr;
    logic [1:0]  next_rst_pend;
    logic        next_sdo_oe_n;
    logic        next_busy;

    fuse_mem u_mem
    (
        .ref_clk_in  (ref_clk_in),
        .wr_en_in    (mem_wr),
        .wr_addr_in  (mem_addr),
        .wr_data_in  (wiper),
        .rd_addr_in  (mem_addr),
        .rd_data_out (mem_q)
    );

    frame_t fr;
    logic [3:0] cmd;
    logic [9:0] arg;
    assign fr.word = shift_in;
    assign fr.ok   = (bit_cnt == 4'h0) & ~misaligned;
    assign fr.fire = frame_end & (lock_cnt == 32'h0);
    assign cmd     = fr.word[`CMD_HI:`CMD_LO];
    assign arg     = fr.word[`DATA_HI:0];

    always_comb
    begin
        next_shift_in   = shift_in;
        next_out_word   = out_word;
        next_bit_cnt    = bit_cnt;
        next_misaligned = misaligned;
        next_prev_word  = prev_word;
        next_rb_kind    = rb_kind;
        next_rb_word    = rb_word;
        next_ctrl       = ctrl;
        next_wiper      = wiper;
        next_last_slot  = last_slot;
        next_shutdown   = shutdown;
        next_sdo_arm    = sdo_arm;
        next_sdo_off    = sdo_off;
        next_lock_cnt   = (lock_cnt != 32'h0) ? lock_cnt - 32'h1 : lock_cnt;
        next_sdo_low    = sdo_low;
        next_mem_wr     = 1'b0;
        next_mem_addr   = mem_addr;
        // Second stage waits for the registered memory read
        next_rst_pend   = {rst_pend[0], 1'b0};

        // Store completes once the lock expires
        if (lock_cnt == 32'h1)
            next_ctrl.done = 1'b1;

        // Reset reload lands once the read data of last_slot is valid
        if (rst_pend[1])
            next_wiper = (last_slot == 6'h0) ? `WIPER_MIDSCALE : mem_q;

        // Output word: readback first, else previous frame word
        if (!sync_n && sync_d)
        begin
            next_bit_cnt    = 4'h0;
            next_misaligned = 1'b0;
            next_out_word   = (rb_kind == RD_NONE) ? prev_word : rb_word;
            if (rb_kind == RD_LOW10)
                next_out_word = {6'h0, wiper};
            else if (rb_kind == RD_MEM)
                next_out_word = {6'h0, mem_q};
        end

        // Output changes on rising serial clock, input sampled on falling
        if (sclk_rise)
        begin
            next_sdo_low  = ~out_word[`FRAME_BITS-1];
            next_out_word = {out_word[14:0], 1'b0};
        end
        if (sclk_fall && lock_cnt == 32'h0)
        begin
            next_shift_in = {shift_in[14:0], din};
            next_bit_cnt  = bit_cnt + 4'h1;
            next_misaligned = 1'b1;
            // Received bit trails the outgoing word, sixteen clocks behind
            next_out_word[0] = din;
        end
        if (sync_n)
            next_sdo_low = 1'b0;

        if (fr.fire)
        begin
            next_rb_kind = RD_NONE;
            next_rb_word = 16'h0;
            next_prev_word = fr.word;
            if (fr.ok)
            begin
                // Parking takes effect once a NOP frame follows the 0x8001 word
                next_sdo_arm = (fr.word == `SDO_OFF_WORD);
                if (sdo_arm && cmd == `CMD_NOP)
                    next_sdo_off = 1'b1;
            end
            if (fr.ok && cmd_defined(cmd))
            begin
                case (cmd)
                    `CMD_WIPER_WR:
                        if (ctrl.unlock)
                            next_wiper = arg;
                    `CMD_WIPER_RD:
                        next_rb_kind = RD_LOW10;
                    `CMD_STORE:
                        if (ctrl.prog_en && last_slot < `LAST_SLOT)
                        begin
                            next_last_slot = (last_slot == 6'h0) ? `FIRST_SLOT
                                                                  : last_slot + 6'h1;
                            next_mem_addr  = next_last_slot;
                            next_mem_wr    = 1'b1;
                            next_ctrl.done = 1'b0;
                            next_lock_cnt  = FUSE_PROG_CYCLES;
                        end
                    `CMD_SW_RESET:
                    begin
                        next_mem_addr = last_slot;
                        next_rst_pend[0] = 1'b1;
                        next_shutdown = 1'b0;
                    end
                    `CMD_FUSE_RD:
                    begin
                        next_mem_addr = arg[`SLOT_HI:0];
                        next_rb_kind  = RD_MEM;
                    end
                    `CMD_LAST_SLOT_RD:
                    begin
                        next_rb_kind = RD_FULL16;
                        next_rb_word = {10'h0, last_slot};
                    end
                    `CMD_CTRL_WR:
                    begin
                        next_ctrl.prog_en = arg[`BIT_PROG_EN];
                        next_ctrl.unlock  = arg[`BIT_WR_UNLOCK];
                        next_ctrl.calib   = arg[`BIT_CALIB_EN];
                    end
                    `CMD_CTRL_RD:
                    begin
                        next_rb_kind = RD_FULL16;
                        next_rb_word = {12'h0, ctrl.done, ctrl.calib,
                                        ctrl.unlock, ctrl.prog_en};
                    end
                    `CMD_SHUTDOWN:
                        next_shutdown = arg[0];
                    default:
                        next_rb_kind = RD_NONE;
                endcase
            end
        end

        // Registered so the pins come straight from flops
        next_sdo_oe_n = ~(next_sdo_low & ~next_sdo_off);
        next_busy     = (next_lock_cnt != 32'h0);
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (!rstn_in)
        begin
            sclk_d     <= 1'b0;
            sync_d     <= 1'b1;
            shift_in   <= 16'h0;
            out_word   <= 16'h0;
            bit_cnt    <= 4'h0;
            misaligned <= 1'b0;
            prev_word  <= 16'h0;
            rb_kind    <= RD_NONE;
            rb_word    <= 16'h0;
            ctrl       <= `CTRL_RESET;
            wiper      <= `WIPER_MIDSCALE;
            last_slot  <= 6'h0;
            shutdown   <= 1'b0;
            sdo_arm    <= 1'b0;
            sdo_off    <= 1'b0;
            lock_cnt   <= 32'h0;
            sdo_low    <= 1'b0;
            mem_wr     <= 1'b0;
            mem_addr   <= 6'h0;
            rst_pend   <= 2'h0;
            sdo_oe_n   <= 1'b1;
            busy       <= 1'b0;
        end
        else
        begin
            sclk_d     <= sclk;
            sync_d     <= sync_n;
            shift_in   <= next_shift_in;
            out_word   <= next_out_word;
            bit_cnt    <= next_bit_cnt;
            misaligned <= (next_bit_cnt != 4'h0) & next_misaligned;
            prev_word  <= next_prev_word;
            rb_kind    <= next_rb_kind;
            rb_word    <= next_rb_word;
            ctrl       <= next_ctrl;
            wiper      <= next_wiper;
            last_slot  <= next_last_slot;
            shutdown   <= next_shutdown;
            sdo_arm    <= next_sdo_arm;
            sdo_off    <= next_sdo_off;
            lock_cnt   <= next_lock_cnt;
            sdo_low    <= next_sdo_low;
            mem_wr     <= next_mem_wr;
            mem_addr   <= next_mem_addr;
            rst_pend   <= next_rst_pend;
            sdo_oe_n   <= next_sdo_oe_n;
            busy       <= next_busy;
        end
    end

    // Open drain: data pin always low, enable only when pulling low
    assign serial_data_out_out         = 1'b0;
    assign serial_data_out_oe_n_out    = sdo_oe_n;
    assign wiper_position_register_out = wiper;
    assign shutdown_out                = shutdown;
    assign tolerance_calib_enable_out  = ctrl.calib;
    assign fuse_busy_out               = busy;

    a_ctrl_reset_zero: assert property (@(posedge ref_clk_in)
        $rose(rstn_in) |-> !ctrl.unlock && !ctrl.prog_en)
        else $error("control enables not zero after reset");

    a_wiper_locked: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        !ctrl.unlock && !rst_pend[1] |=> $stable(wiper))
        else $error("wiper changed while locked");

    a_store_locks: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        mem_wr |-> fuse_busy_out ##1 fuse_busy_out[*8])
        else $error("store did not lock the shifter");

    a_shift_held: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        (lock_cnt > 32'h1) |=> $stable(shift_in))
        else $error("shift register moved during store");

    a_done_on_end: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        lock_cnt == 32'h1 |=> ctrl.done)
        else $error("fuse done not set");

    a_shutdown_exit: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        fr.fire && fr.ok && cmd == `CMD_SW_RESET |=> !shutdown)
        else $error("reset did not leave shutdown");

    a_sdo_parked: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        sdo_off |-> serial_data_out_oe_n_out)
        else $error("output driven while parked");

    a_reset_midscale: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        rst_pend[1] && last_slot == 6'h0 |=> wiper == `WIPER_MIDSCALE)
        else $error("reset without slots not midscale");

    a_ctrl_write: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        fr.fire && fr.ok && fr.word == 16'h1c03 |=> ctrl.unlock && ctrl.prog_en)
        else $error("control unlock word failed");

endmodule : rheo_serial_cmd

// ---- design/rheo_regs.svh ----
/*
 * Command codes, bit positions, reset values and timing counts for the
 * serial rheostat command interpreter.
 * Assumes a 50 MHz system clock; included by the package, and the interpreter module uses its macros.
 */
`ifndef RHEO_REGS_SVH
`define RHEO_REGS_SVH

`define FRAME_BITS          16
`define CMD_HI              13
`define CMD_LO              10
`define DATA_HI             9
`define SLOT_HI             5
`define CMD_NOP             4'h0
`define CMD_WIPER_WR        4'h1
`define CMD_WIPER_RD        4'h2
`define CMD_STORE           4'h3
`define CMD_SW_RESET        4'h4
`define CMD_FUSE_RD         4'h5
`define CMD_LAST_SLOT_RD    4'h6
`define CMD_CTRL_WR         4'h7
`define CMD_CTRL_RD         4'h8
`define CMD_SHUTDOWN        4'h9
`define SDO_OFF_WORD        16'h8001
`define BIT_PROG_EN         0
`define BIT_WR_UNLOCK       1
`define BIT_CALIB_EN        2
`define BIT_FUSE_DONE       3
`define CTRL_RESET          4'h4
`define WIPER_MIDSCALE      10'h200
`define FIRST_SLOT          6'h01
`define LAST_SLOT           6'h32
`define CLK_HZ              50000000
`define FUSE_PROG_MS        350
`define FUSE_PROG_CYCLES    ((`CLK_HZ / 1000) * `FUSE_PROG_MS)

`endif

// ---- design/rheo_pkg.sv ----
/*
 * Types shared by the rheostat command interpreter.
 * Assumes rheo_regs.svh is on the include path.
 */
`include "rheo_regs.svh"

package rheo_pkg;

    typedef enum logic [1:0] {
        RD_NONE,
        RD_LOW10,
        RD_FULL16,
        RD_MEM
    } readback_t;

    // Field order matches the control word: done is bit 3, prog_en bit 0
    typedef struct packed {
        logic       done;
        logic       calib;
        logic       unlock;
        logic       prog_en;
    } ctrl_t;

    typedef struct packed {
        logic       fire;
        logic       ok;
        logic [15:0] word;
    } frame_t;

endpackage : rheo_pkg

// ---- design/pin_sync.sv ----
/*
 * Two-stage synchroniser for the three serial pins.
 * Assumes the pins are asynchronous to ref_clk_in.
 */
`timescale 1ns/1ns

module pin_sync
(
    // Clock and reset
    input  wire logic       ref_clk_in,
    input  wire logic       rstn_in,
    // Raw pins
    input  wire logic [2:0] pins_in,
    // Synchronised copies
    output logic      [2:0] pins_out
);

    logic [2:0] stage1;
    logic [2:0] stage2;

    always_ff @(posedge ref_clk_in)
    begin
        if (!rstn_in)
        begin
            // Idle levels: select high, serial clock low, so no false edge
            stage1 <= 3'h4;
            stage2 <= 3'h4;
        end
        else
        begin
            stage1 <= pins_in;
            stage2 <= stage1;
        end
    end

    assign pins_out = stage2;

endmodule : pin_sync

// ---- design/fuse_mem.sv ----
/*
 * Fuse slot memory: 64 ten-bit words, registered read port.
 * Assumes one write or one read per cycle from the interpreter.
 */
`timescale 1ns/1ns

module fuse_mem
(
    // Clock
    input  wire logic       ref_clk_in,
    // Write port
    input  wire logic       wr_en_in,
    input  wire logic [5:0] wr_addr_in,
    input  wire logic [9:0] wr_data_in,
    // Read port
    input  wire logic [5:0] rd_addr_in,
    output logic      [9:0] rd_data_out
);

    logic [9:0] cells [0:63];

    always_ff @(posedge ref_clk_in)
    begin
        if (wr_en_in)
            cells[wr_addr_in] <= wr_data_in;
        rd_data_out <= cells[rd_addr_in];
    end

endmodule : fuse_mem

// ---- dv/spi_host_model.sv ----
/*
 * Behavioural SPI host that frames words for the rheostat interpreter.
 * Assumes the bench supplies the 50 MHz clock and the pulled-up SERIAL_DATA_OUT level.
 */
`timescale 1ns/1ns

module spi_host_model
(
    // Clock
    input  wire logic ref_clk_in,
    // Serial link
    input  wire logic sdo_in,
    output logic      sync_n_out,
    output logic      sclk_out,
    output logic      din_out
);
    initial
    begin
        sync_n_out = 1'b1;
        sclk_out   = 1'b0;
        din_out    = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge ref_clk_in);
    endtask : wait_clk

    // Command bits 13..10, argument 9..0, sent MSB first
    task automatic xfer(input logic [31:0] w, input int nbits, output logic [31:0] r);
        r = '0;
        wait_clk(1);
        sync_n_out = 1'b0;
        wait_clk(4);
        for (int i = nbits - 1; i >= 0; i--)
        begin
            sclk_out = 1'b1;
            din_out  = w[i];
            wait_clk(4);
            sclk_out = 1'b0;
            wait_clk(4);
            // Late in the low phase, so the synchronised output has settled
            r = {r[30:0], sdo_in};
        end
        sync_n_out = 1'b1; // Raised only after every bit
        din_out    = ~din_out;
        wait_clk(12);
    endtask : xfer
endmodule : spi_host_model

// ---- dv/rheo_serial_cmd_tb_top.sv ----
/*
 * Self-checking bench for the rheostat serial command interpreter.
 * Assumes the design package and header are compiled first.
 */
`timescale 1ns/1ns

module rheo_serial_cmd_tb_top
    import rheo_pkg::*;
;
    logic        ref_clk_in;
    logic        rstn_in;
    logic        sync_n;
    logic        sclk;
    logic        din;
    logic        sdo_data;
    logic        sdo_oe_n;
    logic        sdo_wire;
    logic [9:0]  wiper;
    logic        shutdown;
    logic        calib;
    logic        busy;
    int          n_mismatch;
    int          checks_done;
    int          cyc;
    logic [15:0] r;
    logic [31:0] r32;

    // Pull-up gives the high level when released
    assign sdo_wire = sdo_oe_n ? 1'b1 : sdo_data;

    rheo_serial_cmd #(.FUSE_PROG_CYCLES(400)) uut
    (
        .ref_clk_in                  (ref_clk_in),
        .rstn_in                     (rstn_in),
        .sync_n_in                   (sync_n),
        .sclk_in                     (sclk),
        .din_in                      (din),
        .serial_data_out_out         (sdo_data),
        .serial_data_out_oe_n_out    (sdo_oe_n),
        .wiper_position_register_out (wiper),
        .shutdown_out                (shutdown),
        .tolerance_calib_enable_out  (calib),
        .fuse_busy_out               (busy)
    );

    spi_host_model host
    (
        .ref_clk_in (ref_clk_in),
        .sdo_in     (sdo_wire),
        .sync_n_out (sync_n),
        .sclk_out   (sclk),
        .din_out    (din)
    );

    initial ref_clk_in = 1'b0;
    always #10 ref_clk_in = ~ref_clk_in;

    task automatic stop_test;
        if (n_mismatch == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : stop_test

    // Long store waits set the ceiling
    always @(posedge ref_clk_in)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            n_mismatch++;
            stop_test();
        end
    end

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic frm(input logic [15:0] w, output logic [15:0] rd);
        logic [31:0] t;
        host.xfer({16'h0000, w}, 16, t);
        rd = t[15:0];
    endtask : frm

    task automatic t_reset;
        chk("calib", 16'h0001, {15'h0, calib});
        frm(16'h0500, r);
        frm(16'h0c00, r);
        chk("busy", 16'h0000, {15'h0, busy});
        frm(16'h0800, r);
        frm(16'h0000, r);
        chk("wiper readback", 16'h0200, r);
        frm(16'h2000, r);
        frm(16'h0000, r);
        chk("ctrl readback", 16'h0004, r & 16'h000f);
    endtask : t_reset

    task automatic t_shutdown;
        frm(16'h2401, r);
        chk("shutdown", 16'h0001, {15'h0, shutdown});
        frm(16'h1c03, r);
        frm(16'h0500, r);
        chk("wiper", 16'h0100, {6'h0, wiper});
        frm(16'h2400, r);
        chk("shutdown", 16'h0000, {15'h0, shutdown});
        frm(16'h2401, r);
        frm(16'h1000, r);
        chk("shutdown", 16'h0000, {15'h0, shutdown});
        chk("wiper", 16'h0200, {6'h0, wiper});
    endtask : t_shutdown

    task automatic t_chain;
        frm(16'h1c07, r);
        chk("calib", 16'h0001, {15'h0, calib});
        frm(16'h1c03, r);
        chk("calib", 16'h0000, {15'h0, calib});
        frm(16'h0000, r);
        chk("echo", 16'h1c03, r);
        host.xfer({16'h0123, 16'h0480}, 32, r32);
        chk("chain out", 16'h0123, r32[15:0]);
        chk("chain wiper", 16'h0080, {6'h0, wiper});
        host.xfer(32'h0000_0600, 12, r32);
        chk("short frame", 16'h0080, {6'h0, wiper});
        for (int c = 10; c < 16; c++)
        begin
            frm({2'b00, 4'(c), 10'h3ff}, r);
            chk("undefined code", 16'h0080, {5'h0, shutdown, wiper});
        end
    endtask : t_chain

    task automatic t_store;
        logic [9:0] v;
        int         n;
        for (int s = 1; s <= 25; s++)
        begin
            v = 10'h0ff + 10'(s);
            frm({6'h01, v}, r);
            frm(16'h0c00, r);
            chk("busy", 16'h0001, {15'h0, busy});
            if (s == 1)
            begin
                frm(16'h07ff, r);
                chk("locked wiper", {6'h0, v}, {6'h0, wiper});
            end
            n = 0;
            while (busy !== 1'b0 && n < 1000)
            begin
                @(negedge ref_clk_in);
                n++;
            end
            chk("busy end", 16'h0000, {15'h0, busy});
        end
        frm(16'h2000, r);
        frm(16'h0000, r);
        chk("fuse done", 16'h000b, r & 16'h000f);
        frm(16'h1800, r);
        frm(16'h0000, r);
        chk("last slot", 16'h0019, r & 16'h003f);
        frm(16'h1419, r);
        frm(16'h1401, r);
        chk("slot 0x19", 16'h0118, r);
        frm(16'h0000, r);
        chk("slot 1", 16'h0100, r);
        frm(16'h0600, r);
        frm(16'h1000, r);
        chk("reload", 16'h0118, {6'h0, wiper});
    endtask : t_store

    task automatic t_park;
        frm(16'h8001, r);
        frm(16'h0000, r);
        frm(16'h0800, r);
        frm(16'h0000, r);
        chk("parked out", 16'hffff, r);
        chk("drive level", 16'h0000, {15'h0, sdo_data});
    endtask : t_park

    initial
    begin
        n_mismatch  = 0;
        checks_done = 0;
        cyc         = 0;
        rstn_in     = 1'b0;
        repeat (12) @(negedge ref_clk_in);
        rstn_in = 1'b1;
        repeat (4) @(negedge ref_clk_in);
        t_reset();
        t_shutdown();
        t_chain();
        t_store();
        t_park();
        stop_test();
    end
endmodule : rheo_serial_cmd_tb_top
